// ---- lopd_channel.sv ----
// Purpose: One channel's duty selection, mirroring and pin level compare.
// Assumes: Duty inputs are percent values no larger than one hundred.
// Notes:   Purely combinational; the caller registers the pin controls.
`timescale 1ns/1ps
module lopd_channel (
  input  wire logic       actuated,
  input  wire logic       breathe_sel,
  input  wire logic [7:0] min_duty,
  input  wire logic [7:0] max_duty,
  input  wire logic [7:0] breathe_duty,
  input  wire logic       polarity,
  input  wire logic       mirror_en,
  input  wire logic [7:0] step_count,
  output logic            pin_level
);

  logic [7:0] sel_duty;
  logic [7:0] ref_duty;
  logic       on_phase;

  always_comb begin
    // Idle sits at minimum, direct actuation at maximum, breathe follows the ramp
    if (!actuated) begin
      sel_duty = min_duty;
    end else if (breathe_sel) begin
      sel_duty = breathe_duty;
    end else begin
      sel_duty = max_duty;
    end
    // Mirroring only moves the duty reference, never the pin directly
    if (mirror_en) begin
      ref_duty = lopd_pkg::DUTY_FULL - sel_duty;
    end else begin
      ref_duty = sel_duty;
    end
    on_phase = (step_count < ref_duty);
    // Polarity set counts high time, polarity clear counts low time
    pin_level = polarity ? on_phase : ~on_phase;
  end

endmodule

// ---- lopd_drive.sv ----
// Purpose: Output stage for eleven LED pins with polarity, mirror and drive control.
// Assumes: Host register port, link bits, touch flags and duty settings are synchronous.
// Notes:   Behaviour engine, sensing and direction/type registers live outside.
`timescale 1ns/1ps

module lopd_drive (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic        block_polarity_mirror_sync,
  input  wire logic [10:0] ch_pin_direction,
  input  wire logic [10:0] ch_output_type,
  input  wire logic [10:0] sensor_link,
  input  wire logic [10:0] touch_detect,
  input  wire logic [10:0] breathe_sel,
  input  wire logic [87:0] min_duty,
  input  wire logic [87:0] max_duty,
  input  wire logic [87:0] breathe_duty,
  output logic [10:0]      led_out,
  output logic [10:0]      led_oe,
  output logic [10:0]      ch_actuated
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [lopd_pkg::DIV_W-1:0] div_count;
    logic [7:0]                 step_count;
    logic [10:0]                drive_request;
    logic [10:0]                channel_polarity;
    logic [10:0]                duty_reference_full_scale;
    logic [7:0]                 rdata;
    logic [10:0]                pin_out;
    logic [10:0]                pin_oe;
    logic [10:0]                actuated;
  } lopd_state_type;

  lopd_state_type state;
  lopd_state_type next_state;

  logic [10:0] link_eff;
  logic [10:0] act_now;
  logic [10:0] level_now;
  logic        step_tick;

  // ----------------------------------------------------------------
  // Link resolution and actuation
  // ----------------------------------------------------------------
  always_comb begin
    link_eff = sensor_link;
    // Eighth and eleventh pins have no sensor path at all
    link_eff[lopd_pkg::CH_NO_LINK_A] = 1'b0;
    link_eff[lopd_pkg::CH_NO_LINK_B] = 1'b0;
    // Grouping the up channel drags the down channel into the group
    link_eff[lopd_pkg::CH_GROUP_DOWN] = sensor_link[lopd_pkg::CH_GROUP_DOWN]
                                      | sensor_link[lopd_pkg::CH_GROUP_UP];
  end

  always_comb begin
    for (int i = 0; i < lopd_pkg::NUM_CH; i++) begin
      // A link on an input pin is ignored, so the control bit decides actuation there
      if (link_eff[i] && ch_pin_direction[i]) begin
        act_now[i] = touch_detect[i];
      end else begin
        act_now[i] = state.drive_request[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-channel duty compare
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < lopd_pkg::NUM_CH; g++) begin : gen_ch
      lopd_channel u_channel (
        .actuated     (act_now[g]),
        .breathe_sel  (breathe_sel[g]),
        .min_duty     (min_duty[g*8 +: 8]),
        .max_duty     (max_duty[g*8 +: 8]),
        .breathe_duty (breathe_duty[g*8 +: 8]),
        .polarity     (state.channel_polarity[g]),
        .mirror_en    (state.duty_reference_full_scale[g]),
        .step_count   (state.step_count),
        .pin_level    (level_now[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    step_tick  = (state.div_count == lopd_pkg::DIV_LAST);

    // Step divider and free-running percent counter
    if (step_tick) begin
      next_state.div_count = '0;
      if (state.step_count == lopd_pkg::PERIOD_LAST) begin
        next_state.step_count = 8'h00;
      end else begin
        next_state.step_count = state.step_count + 8'h01;
      end
    end else begin
      next_state.div_count = state.div_count + lopd_pkg::DIV_W'(1);
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        lopd_pkg::ADDR_OUT_CTRL_LOW: begin
          next_state.drive_request[7:0] = reg_wdata;
        end
        lopd_pkg::ADDR_OUT_CTRL_HIGH: begin
          next_state.drive_request[10:8] = reg_wdata[2:0];
        end
        lopd_pkg::ADDR_POL_LOW: begin
          next_state.channel_polarity[7:0] = reg_wdata;
          if (!block_polarity_mirror_sync) begin
            next_state.duty_reference_full_scale[7:0] = reg_wdata;
          end
        end
        lopd_pkg::ADDR_POL_HIGH: begin
          next_state.channel_polarity[10:8] = reg_wdata[2:0];
          if (!block_polarity_mirror_sync) begin
            next_state.duty_reference_full_scale[10:8] = reg_wdata[2:0];
          end
        end
        lopd_pkg::ADDR_MIRROR_LOW: begin
          next_state.duty_reference_full_scale[7:0] = reg_wdata;
        end
        lopd_pkg::ADDR_MIRROR_HIGH: begin
          next_state.duty_reference_full_scale[10:8] = reg_wdata[2:0];
        end
        default: begin
          next_state.drive_request = state.drive_request;
        end
      endcase
    end

    // Register reads, unused upper bits read as zero
    if (reg_rd) begin
      case (reg_addr)
        lopd_pkg::ADDR_OUT_CTRL_LOW: begin
          next_state.rdata = state.drive_request[7:0];
        end
        lopd_pkg::ADDR_OUT_CTRL_HIGH: begin
          next_state.rdata = {5'h00, state.drive_request[10:8]};
        end
        lopd_pkg::ADDR_POL_LOW: begin
          next_state.rdata = state.channel_polarity[7:0];
        end
        lopd_pkg::ADDR_POL_HIGH: begin
          next_state.rdata = {5'h00, state.channel_polarity[10:8]};
        end
        lopd_pkg::ADDR_MIRROR_LOW: begin
          next_state.rdata = state.duty_reference_full_scale[7:0];
        end
        lopd_pkg::ADDR_MIRROR_HIGH: begin
          next_state.rdata = {5'h00, state.duty_reference_full_scale[10:8]};
        end
        default: begin
          next_state.rdata = lopd_pkg::READ_UNMAPPED;
        end
      endcase
    end

    // Pin drive: open drain releases for a high level, push-pull drives both
    next_state.actuated = act_now;
    for (int i = 0; i < lopd_pkg::NUM_CH; i++) begin
      if (!ch_pin_direction[i]) begin
        next_state.pin_out[i] = 1'b0;
        next_state.pin_oe[i]  = 1'b0;
      end else if (ch_output_type[i]) begin
        next_state.pin_out[i] = level_now[i];
        next_state.pin_oe[i]  = 1'b1;
      end else begin
        next_state.pin_out[i] = 1'b0;
        next_state.pin_oe[i]  = ~level_now[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state.div_count                 <= '0;
      state.step_count                <= 8'h00;
      state.drive_request             <= lopd_pkg::RST_CH_BITS;
      state.channel_polarity          <= lopd_pkg::RST_CH_BITS;
      state.duty_reference_full_scale <= lopd_pkg::RST_CH_BITS;
      state.rdata                     <= lopd_pkg::READ_UNMAPPED;
      state.pin_out                   <= lopd_pkg::RST_CH_BITS;
      state.pin_oe                    <= lopd_pkg::RST_CH_BITS;
      state.actuated                  <= lopd_pkg::RST_CH_BITS;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata   = state.rdata;
  assign led_out     = state.pin_out;
  assign led_oe      = state.pin_oe;
  assign ch_actuated = state.actuated;

endmodule

// ---- lopd_drive_asserts.sv ----
// Purpose: Port-level assertions for the LED output stage.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Pin checks look back one cycle at their cause.
`timescale 1ns/1ps
module lopd_drive_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [10:0] ch_pin_direction,
  input wire logic [10:0] ch_output_type,
  input wire logic [10:0] sensor_link,
  input wire logic [10:0] touch_detect,
  input wire logic [10:0] led_out,
  input wire logic [10:0] led_oe,
  input wire logic [10:0] ch_actuated
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Pin and register checks
  // ----------------------------------------
  a_input_pin_quiet: assert property (
    $past(rst_b) |-> ((led_oe | led_out) & ~$past(ch_pin_direction)) == 11'h000)
    else $error("input pin driven");
  a_open_drain_low: assert property (
    $past(rst_b) |-> (led_out & ~$past(ch_output_type)) == 11'h000)
    else $error("open drain pin high");
  a_push_pull_on: assert property (
    $past(rst_b) |-> (~led_oe & $past(ch_pin_direction) & $past(ch_output_type)) == 11'h000)
    else $error("push-pull pin released");
  a_unlinked_steady: assert property (
    $past(rst_b) && $past(rst_b, 2) && !$past(reg_wr) && !$past(reg_wr, 2)
    |-> $stable(ch_actuated[7]) && $stable(ch_actuated[10]))
    else $error("unlinked channel moved");
  a_link_touch: assert property (
    $past(rst_b) |-> ((ch_actuated ^ $past(touch_detect)) & $past(sensor_link)
      & $past(ch_pin_direction) & 11'h37f) == 11'h000)
    else $error("linked channel ignores touch");
  a_group_link: assert property (
    $past(rst_b) && $past(sensor_link[9]) && $past(ch_pin_direction[8])
    |-> ch_actuated[8] == $past(touch_detect[8]))
    else $error("group link missing");
  a_unmapped_zero: assert property (
    reg_rd && !(reg_addr inside {[8'h73:8'h76], 8'h79, 8'h7a}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (
    $past(rst_b) && !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");
endmodule
bind lopd_drive lopd_drive_asserts u_lopd_drive_asserts (.ref_clk, .rst_b, .reg_addr,
  .reg_wr, .reg_rd, .reg_rdata, .ch_pin_direction, .ch_output_type, .sensor_link,
  .touch_detect, .led_out, .led_oe, .ch_actuated);

// ---- lopd_drive_tb_top.sv ----
// Purpose: Random self-checking bench for the LED output stage.
// Assumes: Step counter moves every 1000 clocks from reset.
// Notes:   Pins are not judged near a step edge, where alignment is open.
`timescale 1ns/1ps
module lopd_drive_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        blk_sync = 1'b0;
  logic [7:0]  reg_rdata;
  logic [10:0] dir = '0, otype = '0, link = '0, touch = '0, brs = '0;
  logic [10:0] led_out, led_oe, act, lit;
  logic [87:0] dmin = '0, dmax = '0, dbr = '0;
  logic [7:0]  mreg [256] = '{default: 8'h00};
  logic [7:0]  regs [7] = '{8'h73, 8'h74, 8'h75, 8'h76, 8'h79, 8'h7a, 8'h77};
  int          miscompares = 0, n_checks = 0, seed = 39586, cyc = 0;

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (rst_b)
      cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end

  lopd_drive u_lopd_drive (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .block_polarity_mirror_sync(blk_sync), .ch_pin_direction(dir),
    .ch_output_type(otype), .sensor_link(link), .touch_detect(touch), .breathe_sel(brs),
    .min_duty(dmin), .max_duty(dmax), .breathe_duty(dbr), .led_out, .led_oe,
    .ch_actuated(act));
  lopd_led_load u_lopd_led_load (.led_out, .led_oe, .lit);

  task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] k;
    k = (a inside {8'h74, 8'h76, 8'h7a}) ? 8'h07 : 8'hff;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
    reg_rd = 1'b0;
    if (!w)
      cmp(11'(reg_rdata), 11'(mreg[a]));
    else if (a inside {[8'h73:8'h76], 8'h79, 8'h7a})
      mreg[a] = d & k;
    if (w && a inside {8'h75, 8'h76} && !blk_sync)
      mreg[a + 8'h04] = d & k;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic pins();
    logic [10:0] ea, eo, ee, lv, dr, pol, mir;
    logic        lk;
    int          duty;
    if (cyc % 1000 < 4 || cyc % 1000 > 996)
      return;
    dr = {mreg[8'h74][2:0], mreg[8'h73]};
    pol = {mreg[8'h76][2:0], mreg[8'h75]};
    mir = {mreg[8'h7a][2:0], mreg[8'h79]};
    for (int i = 0; i < 11; i++) begin
      lk = (i == 7 || i == 10) ? 1'b0 : (i == 8) ? link[8] | link[9] : link[i];
      ea[i] = (lk && dir[i]) ? touch[i] : dr[i];
      duty = !ea[i] ? dmin[8*i+:8] : brs[i] ? dbr[8*i+:8] : dmax[8*i+:8];
      if (mir[i])
        duty = 100 - duty;
      lv[i] = pol[i] ~^ (cyc / 1000 < duty);
      ee[i] = dir[i] & (otype[i] | ~lv[i]);
      eo[i] = dir[i] & otype[i] & lv[i];
    end
    cmp(act, ea);
    cmp(led_out, eo);
    cmp(led_oe, ee);
    cmp(lit, ee & ~eo);
  endtask

  function automatic logic [7:0] rdu();
    int unsigned r;
    r = $unsigned($random(seed));
    return r[0] ? 8'(r % 8) : 8'(r % 101);
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    foreach (regs[j])
      bus(1'b0, regs[j], 8'h00);
    $display("reset values done");
    for (int n = 0; n < 300; n++) begin
      blk_sync = 1'($random(seed));
      {dir, otype, link, touch, brs} = 55'({$random(seed), $random(seed)});
      for (int i = 0; i < 11; i++) begin
        dmin[8*i+:8] = rdu();
        dmax[8*i+:8] = rdu();
        dbr[8*i+:8] = rdu();
      end
      bus(1'b1, regs[$unsigned($random(seed)) % 7], 8'($random(seed)));
      bus(1'b0, regs[$unsigned($random(seed)) % 7], 8'h00);
      repeat (1 + $unsigned($random(seed)) % 40) @(posedge ref_clk);
      #1 pins();
      // Touch moves alone here, away from writes, so unlinked pins must ignore it
      touch = 11'($random(seed));
      repeat (3) @(posedge ref_clk);
      #1 pins();
    end
    $display("random drive done");
    conclude();
  end
endmodule

// ---- lopd_led_load.sv ----
// Purpose: Behavioural LEDs hanging from the supply on each driver pin.
// Assumes: A low pin sinks current and lights its LED.
// Notes:   A released pin floats to the pull-up level and stays dark.
`timescale 1ns/1ps
module lopd_led_load (
  input  wire logic [10:0] led_out,
  input  wire logic [10:0] led_oe,
  output logic [10:0]      lit
);
  logic [10:0] pin_level;
  assign pin_level = (led_oe & led_out) | ~led_oe;
  assign lit = ~pin_level;
endmodule

// ---- lopd_pkg.sv ----
// Purpose: Shared constants for the LED output polarity and drive stage.
// Assumes: Register port is a plain byte-wide address/data port from the host interface.
// Notes:   Duty settings are whole percent values from 0 to 100.
package lopd_pkg;

  // ----------------------------------------------------------------
  // Channel layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH        = 11;
  localparam int unsigned LOW_CH        = 8;
  localparam int unsigned HIGH_CH       = 3;
  localparam int unsigned CH_NO_LINK_A  = 7;   // Eighth channel, zero based
  localparam int unsigned CH_NO_LINK_B  = 10;  // Eleventh channel, zero based
  localparam int unsigned CH_GROUP_DOWN = 8;   // Ninth channel, zero based
  localparam int unsigned CH_GROUP_UP   = 9;   // Tenth channel, zero based

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OUT_CTRL_LOW  = 8'h73;
  localparam logic [7:0] ADDR_OUT_CTRL_HIGH = 8'h74;
  localparam logic [7:0] ADDR_POL_LOW       = 8'h75;
  localparam logic [7:0] ADDR_POL_HIGH      = 8'h76;
  localparam logic [7:0] ADDR_MIRROR_LOW    = 8'h79;
  localparam logic [7:0] ADDR_MIRROR_HIGH   = 8'h7a;

  localparam logic [7:0]  RST_OUT_CTRL = 8'h00;
  localparam logic [7:0]  RST_POL      = 8'h00;
  localparam logic [7:0]  RST_MIRROR   = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED = 8'h00;
  localparam logic [10:0] RST_CH_BITS  = 11'h000;

  // ----------------------------------------------------------------
  // Duty and period timing
  // ----------------------------------------------------------------
  localparam int unsigned DUTY_W       = 8;
  localparam logic [7:0]  DUTY_FULL    = 8'h64;   // One hundred percent
  localparam logic [7:0]  PERIOD_LAST  = 8'h63;   // Step count wraps after 99
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned STEP_TIME_NS  = 50000;  // Time of one percent step
  localparam int unsigned STEP_CYCLES   =
    (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_W         = 10;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_CYCLES - 1);

endpackage
